// File: shared/dcache_readout_defs.vh
// Constants for the data cache tag and status readout path.
`ifndef DCACHE_READOUT_DEFS_VH
`define DCACHE_READOUT_DEFS_VH

`define SET_IDX_HI       10
`define SET_IDX_LO       6
`define ELEM_IDX_HI      13
`define ELEM_IDX_LO      11
`define NUM_SETS         32
`define NUM_ELEMS        8
`define LRU_W            10
`define DIRTY_W          8
`define TAG_W            22
`define STAT_LRU_LO      0
`define STAT_DIRTY_LO    10
`define OFS_W            7
`define STATUS_STALL_CYC 2
`define OP_NONE          2'h0
`define OP_STATUS        2'h1
`define OP_TAG           2'h2

`endif

// File: rtl/dcache_tag_copy.v
// One copy of data cache tag and status storage with a read-only port.
`timescale 1ns/1ps
`default_nettype none
`include "dcache_readout_defs.vh"

module dcache_tag_copy (
    // Clock and reset
    input  wire                     clk,
    input  wire                     resetn,
    // Update port from the cache controller
    input  wire                     upd_tag_en,
    input  wire [7:0]               upd_block,
    input  wire [`TAG_W-1:0]        upd_tag,
    input  wire                     upd_stat_en,
    input  wire [4:0]               upd_set,
    input  wire [`LRU_W-1:0]        upd_lru,
    input  wire [`DIRTY_W-1:0]      upd_dirty,
    // Readout port, combinational
    input  wire [4:0]               rd_set,
    input  wire [2:0]               rd_elem,
    output wire [`TAG_W-1:0]        rd_tag,
    output wire [`LRU_W-1:0]        rd_lru,
    output wire [`DIRTY_W-1:0]      rd_dirty
);

    reg [`TAG_W-1:0]   tag_mem   [0:`NUM_SETS*`NUM_ELEMS-1];
    reg [`LRU_W-1:0]   lru_mem   [0:`NUM_SETS-1];
    reg [`DIRTY_W-1:0] dirty_mem [0:`NUM_SETS-1];

    // Only the cache controller writes here; the readout port never does.
    always @(posedge clk) begin
        if (upd_tag_en) begin
            tag_mem[upd_block] <= upd_tag;
        end
        if (upd_stat_en) begin
            lru_mem[upd_set]   <= upd_lru;
            dirty_mem[upd_set] <= upd_dirty;
        end
    end

    assign rd_tag   = tag_mem[{rd_set, rd_elem}];
    assign rd_lru   = lru_mem[rd_set];
    assign rd_dirty = dirty_mem[rd_set];

endmodule
`default_nettype wire

// File: rtl/dcache_tag_status_readout.v
// Diagnostic readout of data cache tags and LRU/dirty status per port.
//
// Contract
// - Status read indexes set with sum bits 10..6
// - Status result: LRU 9..0, dirty 17..10
// - Status read stalls pipeline two cycles
// - Tag read: set bits 10..6, element 13..11
// - Tag result in bits 21..0, upper zero
// - Tag read inserts no stall cycles
// - Status read uses its slot's copy
// - Tag read uses its slot's copy
// - Guard LSB zero leaves destination unchanged
`timescale 1ns/1ps
`default_nettype none
`include "dcache_readout_defs.vh"

module dcache_tag_status_readout (
    // Clock and reset
    input  wire                     clk,
    input  wire                     resetn,
    // Operation issue
    input  wire                     op_valid,
    input  wire [1:0]               op_kind,
    input  wire                     op_port,
    input  wire [31:0]              base_operand,
    input  wire [`OFS_W-1:0]        op_offset,
    input  wire                     guard_present,
    input  wire [31:0]              guard_value,
    input  wire [6:0]               op_dest,
    // Cache controller update, one group per port copy
    input  wire [1:0]               upd_tag_en,
    input  wire [15:0]              upd_block,
    input  wire [2*`TAG_W-1:0]      upd_tag,
    input  wire [1:0]               upd_stat_en,
    input  wire [9:0]               upd_set,
    input  wire [2*`LRU_W-1:0]      upd_lru,
    input  wire [2*`DIRTY_W-1:0]    upd_dirty,
    // Result to the register file and pipeline
    output reg                      stall_r,
    output reg                      wr_en_r,
    output reg  [6:0]               wr_dest_r,
    output reg  [31:0]              wr_data_r
);

    localparam ST_IDLE  = 2'h0;
    localparam ST_STALL = 2'h1;

    // The modifier is a signed word count, so -64..63 words covers the
    // documented byte range; the encoder keeps software inside it.
    function [31:0] eff_addr;
        input [31:0]        base;
        input [`OFS_W-1:0]  ofs;
        begin
            eff_addr = base + {{23{ofs[`OFS_W-1]}}, ofs, 2'b00};
        end
    endfunction

    wire [31:0] addr = eff_addr(base_operand, op_offset);
    wire [4:0]  rd_set  = addr[`SET_IDX_HI:`SET_IDX_LO];
    wire [2:0]  rd_elem = addr[`ELEM_IDX_HI:`ELEM_IDX_LO];

    wire [`TAG_W-1:0]   tag_p   [0:1];
    wire [`LRU_W-1:0]   lru_p   [0:1];
    wire [`DIRTY_W-1:0] dirty_p [0:1];

    // Two independent copies; the read ports are observation only.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_copy
            dcache_tag_copy u_copy (
                .clk         (clk),
                .resetn      (resetn),
                .upd_tag_en  (upd_tag_en[gi]),
                .upd_block   (upd_block[gi*8 +: 8]),
                .upd_tag     (upd_tag[gi*`TAG_W +: `TAG_W]),
                .upd_stat_en (upd_stat_en[gi]),
                .upd_set     (upd_set[gi*5 +: 5]),
                .upd_lru     (upd_lru[gi*`LRU_W +: `LRU_W]),
                .upd_dirty   (upd_dirty[gi*`DIRTY_W +: `DIRTY_W]),
                .rd_set      (rd_set),
                .rd_elem     (rd_elem),
                .rd_tag      (tag_p[gi]),
                .rd_lru      (lru_p[gi]),
                .rd_dirty    (dirty_p[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Result formatting.

    wire [31:0] stat_word = {14'h0000, dirty_p[op_port],
                             lru_p[op_port]};
    wire [31:0] tag_word  = {10'h000, tag_p[op_port]};

    wire guard_ok = !guard_present || guard_value[0];

    ////////////////////////////////////////////////////////////////////////
    // Sequencing: the status read holds its result for the stall cycles.

    reg [1:0]  state_r;
    reg [1:0]  state_nxt;
    reg [1:0]  cnt_r;
    reg [1:0]  cnt_nxt;
    reg [31:0] hold_data_r;
    reg [6:0]  hold_dest_r;
    reg        hold_wr_r;

    reg        wr_en_nxt;
    reg [31:0] wr_data_nxt;
    reg [6:0]  wr_dest_nxt;
    reg        stall_nxt;

    always @* begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        wr_en_nxt   = 1'b0;
        wr_data_nxt = wr_data_r;
        wr_dest_nxt = wr_dest_r;
        stall_nxt   = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (op_valid && op_kind == `OP_TAG) begin
                    wr_en_nxt   = guard_ok;
                    wr_data_nxt = tag_word;
                    wr_dest_nxt = op_dest;
                end else if (op_valid && op_kind == `OP_STATUS) begin
                    state_nxt = ST_STALL;
                    cnt_nxt   = 2'd`STATUS_STALL_CYC;
                    stall_nxt = 1'b1;
                end
            end
            ST_STALL: begin
                if (cnt_r == 2'd1) begin
                    state_nxt   = ST_IDLE;
                    cnt_nxt     = 2'd0;
                    wr_en_nxt   = hold_wr_r;
                    wr_data_nxt = hold_data_r;
                    wr_dest_nxt = hold_dest_r;
                end else begin
                    cnt_nxt   = cnt_r - 2'd1;
                    stall_nxt = 1'b1;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                cnt_nxt   = 2'd0;
            end
        endcase
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r     <= ST_IDLE;
            cnt_r       <= 2'd0;
            stall_r     <= 1'b0;
            wr_en_r     <= 1'b0;
            wr_data_r   <= 32'h00000000;
            wr_dest_r   <= 7'h00;
            hold_data_r <= 32'h00000000;
            hold_dest_r <= 7'h00;
            hold_wr_r   <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            stall_r   <= stall_nxt;
            wr_en_r   <= wr_en_nxt;
            wr_data_r <= wr_data_nxt;
            wr_dest_r <= wr_dest_nxt;
            // Capture at issue so later cache updates cannot skew the result.
            if (state_r == ST_IDLE && op_valid && op_kind == `OP_STATUS) begin
                hold_data_r <= stat_word;
                hold_dest_r <= op_dest;
                hold_wr_r   <= guard_ok;
            end
        end
    end

endmodule
`default_nettype wire

// File: tb/dcache_readout_asserts.sv
// Timing and result-shape checker for the cache readout block.
`timescale 1ns/1ps
`default_nettype none
module dcache_readout_asserts (
    // Watched ports
    input wire logic        clk, resetn, op_valid, guard_present,
    input wire logic        stall_r, wr_en_r,
    input wire logic [1:0]  op_kind,
    input wire logic [6:0]  op_dest, wr_dest_r,
    input wire logic [31:0] guard_value, wr_data_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // A request counts only when the stall has already cleared.
    logic ok, tg, st, go_t, go_s;
    assign ok = !guard_present || guard_value[0];
    assign tg = op_valid && !stall_r && op_kind == 2'h2;
    assign st = op_valid && !stall_r && op_kind == 2'h1;
    assign go_t = tg && ok;
    assign go_s = st && ok;
    property p_tag_now; go_t |=> wr_en_r && !stall_r; endproperty
    a_tag_now: assert property (p_tag_now) else $error("tag late");
    property p_tag_res;
        go_t |=> wr_dest_r == $past(op_dest) && wr_data_r[31:22] == 10'h0;
    endproperty
    a_tag_res: assert property (p_tag_res) else $error("tag res");
    property p_stall; st |=> stall_r [*2] ##1 !stall_r; endproperty
    a_stall: assert property (p_stall) else $error("stall");
    property p_stat_wr;
        go_s |=> !wr_en_r ##1 !wr_en_r ##1 wr_en_r && wr_data_r[31:18] == 14'h0;
    endproperty
    a_stat_wr: assert property (p_stat_wr) else $error("stat");
    property p_stat_dst; go_s |=> ##2 wr_dest_r == $past(op_dest, 3); endproperty
    a_stat_dst: assert property (p_stat_dst) else $error("dest");
    property p_tag_off; tg && !ok |=> !wr_en_r; endproperty
    a_tag_off: assert property (p_tag_off) else $error("guard");
    property p_stat_off; st && !ok |=> ##2 !wr_en_r; endproperty
    a_stat_off: assert property (p_stat_off) else $error("guard");
    property p_cause; wr_en_r |-> $past(go_t) || $past(go_s, 3); endproperty
    a_cause: assert property (p_cause) else $error("stray write");
endmodule
bind dcache_tag_status_readout dcache_readout_asserts u_chk (.*);
`default_nettype wire

// File: tb/regfile_model.sv
// Register file model that keeps what the readout block writes back.
`timescale 1ns/1ps
`default_nettype none
module regfile_model (
    // Write port
    input wire logic        clk,
    input wire logic        wr_en_r,
    input wire logic [6:0]  wr_dest_r,
    input wire logic [31:0] wr_data_r
);
    logic [31:0] regs [0:127];
    // Without a write strobe the old contents must survive untouched.
    always @(posedge clk) begin
        if (wr_en_r === 1'b1) regs[wr_dest_r] <= wr_data_r;
    end
endmodule
`default_nettype wire

// File: tb/dcache_tag_status_readout_tb_top.sv
// Self-checking bench for the cache tag and status readout block.
`timescale 1ns/1ps
`default_nettype none
`include "dcache_readout_defs.vh"
module dcache_tag_status_readout_tb_top;
    logic clk = 0, resetn = 0, op_valid = 0, op_port = 0, guard_present = 0;
    logic [1:0] op_kind = 0, upd_tag_en = 0, upd_stat_en = 0;
    logic [31:0] base_operand = 0, guard_value = 0, wr_data_r;
    logic [6:0] op_offset = 0, op_dest = 0, wr_dest_r;
    logic [15:0] upd_block = 0, upd_dirty = 0;
    logic [43:0] upd_tag = 0;
    logic [9:0] upd_set = 0;
    logic [19:0] upd_lru = 0;
    logic stall_r, wr_en_r;
    int n_fail = 0, comparisons = 0;
    logic use_guard = 1'b1;
    always #50 clk = ~clk;
    dcache_tag_status_readout dut (.*);
    regfile_model m_rf (.*);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask
    // Block number is {set, element}; status is {dirty, lru}.
    task automatic put(input logic p, input logic [7:0] b,
                       input logic [21:0] t, input logic [17:0] s);
        @(posedge clk);
        upd_tag_en[p] <= 1'b1;
        upd_stat_en[p] <= 1'b1;
        upd_block[p*8 +: 8] <= b;
        upd_set[p*5 +: 5] <= b[7:3];
        upd_tag[p*22 +: 22] <= t;
        upd_lru[p*10 +: 10] <= s[9:0];
        upd_dirty[p*8 +: 8] <= s[17:10];
        @(posedge clk);
        upd_tag_en <= 2'h0;
        upd_stat_en <= 2'h0;
    endtask
    // Waits out the documented latency so the model has the result.
    task automatic op(input logic [1:0] k, input logic p, input logic [31:0] b,
                      input logic [6:0] o, input logic [31:0] g,
                      input logic [6:0] d);
        @(posedge clk);
        op_valid <= 1'b1;
        op_kind <= k;
        op_port <= p;
        base_operand <= b;
        op_offset <= o;
        guard_present <= use_guard;
        guard_value <= g;
        op_dest <= d;
        @(posedge clk);
        op_valid <= 1'b0;
        repeat (k == `OP_STATUS ? 3 : 1) @(posedge clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_tag;
        put(1'b0, 8'h9d, 22'h2a5a5a, 18'h2d2a5);
        put(1'b1, 8'h9d, 22'h15a5a5, 18'h12d5a);
        op(`OP_TAG, 1'b0, 32'h2dc4, 7'h40, 32'h1, 7'h10);
        chk(m_rf.regs[7'h10], 32'h002a5a5a);
        op(`OP_TAG, 1'b1, 32'h2bc4, 7'h3f, 32'h1, 7'h11);
        chk(m_rf.regs[7'h11], 32'h0015a5a5);
        $display("t_tag done");
    endtask
    task automatic t_stat;
        op(`OP_STATUS, 1'b0, 32'h2cc0, 7'h00, 32'h1, 7'h20);
        chk(m_rf.regs[7'h20], 32'h0002d2a5);
        op(`OP_STATUS, 1'b1, 32'h04bc, 7'h01, 32'h1, 7'h21);
        chk(m_rf.regs[7'h21], 32'h00012d5a);
        $display("t_stat done");
    endtask
    task automatic t_guard;
        op(`OP_TAG, 1'b1, 32'h2cc0, 7'h00, 32'h2, 7'h10);
        chk(m_rf.regs[7'h10], 32'h002a5a5a);
        op(`OP_STATUS, 1'b1, 32'h2cc0, 7'h00, 32'h2, 7'h20);
        chk(m_rf.regs[7'h20], 32'h0002d2a5);
        op(`OP_STATUS, 1'b0, 32'h2cc0, 7'h00, 32'h3, 7'h22);
        chk(m_rf.regs[7'h22], 32'h0002d2a5);
        // With no guard given, a zero guard value must not block the write.
        use_guard = 1'b0;
        op(`OP_TAG, 1'b0, 32'h2cc0, 7'h00, 32'h0, 7'h12);
        chk(m_rf.regs[7'h12], 32'h002a5a5a);
        use_guard = 1'b1;
        $display("t_guard done");
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        t_tag;
        t_stat;
        t_guard;
        tally_and_finish;
    end
    initial begin
        #2000000;
        n_fail++;
        $display("BAD %0t run too long", $time);
        tally_and_finish;
    end
endmodule
`default_nettype wire
